// >>> common/modem_cfg_pkg.sv
// Package of offsets, field layouts and reset values for the modem configuration registers.
`default_nettype none
package modem_cfg_pkg;
  // ****************************************************************
  // Register addresses. The register indices are not all multiples of four,
  // so each one is kept as an index and the byte address is four times it.
  // ****************************************************************
  localparam logic [7:0] IDX_FREQ_DEVIATION_CFG = 8'h0E;
  localparam logic [7:0] IDX_FREQ_TRACK_CFG = 8'h0F;
  localparam logic [7:0] IDX_CHANNEL_FILTER_CFG = 8'h10;
  localparam logic [9:0] ADDR_FREQ_DEVIATION_CFG = {IDX_FREQ_DEVIATION_CFG, 2'b00};
  localparam logic [9:0] ADDR_FREQ_TRACK_CFG = {IDX_FREQ_TRACK_CFG, 2'b00};
  localparam logic [9:0] ADDR_CHANNEL_FILTER_CFG = {IDX_CHANNEL_FILTER_CFG, 2'b00};
  localparam int ADDR_WIDTH = 10;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int TX_SHAPING_BIT = 7;
  localparam int TX_DEV_EXP_LSB = 4;
  localparam int TX_DEV_MAN_LSB = 0;
  localparam int SETTLING_LSB = 6;
  localparam int RX_DEV_EXP_LSB = 4;
  localparam int RX_DEV_MAN_LSB = 0;
  localparam int FILTER_BYPASS_BIT = 7;
  localparam int DECIM_SHIFT_LSB = 5;
  localparam int DECIM_DIV_LSB = 0;

  // ****************************************************************
  // Field reset values.
  // ****************************************************************
  localparam logic RST_TX_SHAPING = 1'b1;
  localparam logic [2:0] RST_TX_DEV_EXP = 3'h6;
  localparam logic [3:0] RST_TX_DEV_MAN = 4'h8;
  localparam logic [1:0] RST_SETTLING = 2'h2;
  localparam logic [1:0] RST_RX_DEV_EXP = 2'h1;
  localparam logic [3:0] RST_RX_DEV_MAN = 4'hC;
  localparam logic RST_FILTER_BYPASS = 1'b0;
  localparam logic [1:0] RST_DECIM_SHIFT = 2'h0;
  localparam logic [4:0] RST_DECIM_DIV = 5'h00;

  // ****************************************************************
  // Exponent offsets and other derived constants.
  // ****************************************************************
  localparam int TX_EXP_BIAS_LOW = 16;
  localparam int TX_EXP_BIAS_HIGH = 15;
  localparam int RX_EXP_BIAS = 3;
  localparam int RX_DEV_DIVISOR = 3;
  localparam int BAUD_CLK_DIVISOR = 8;
  localparam logic [3:0] OOK_MANTISSA = 4'h0;
  localparam logic [5:0] AFC_PAIRS_OFF = 6'h00;

  // AFC settling codes.
  typedef enum logic [1:0]
  {
    AFC_OFF = 2'h0,
    AFC_FAST = 2'h1,
    AFC_MEDIUM = 2'h2,
    AFC_SLOW = 2'h3
  } afc_mode_type;
endpackage : modem_cfg_pkg
`default_nettype wire

// >>> hw/modem_baud_divider.sv
// Divides the modem clock tick stream down to one baud tick every eight ticks.
`timescale 1ns/10ps
`default_nettype none
module modem_baud_divider
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Modem clock tick in, baud tick out.
  input wire logic modem_tick,
  output logic baud_tick
);
  // ****************************************************************
  // Tick counter
  // ****************************************************************
  logic [2:0] count_reg; // Counts modem ticks within one baud period.

  // The baud tick is one modem tick in eight, so the counter wraps on its own.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count_reg <= 3'h0;
    end
    else if (modem_tick)
    begin
      count_reg <= count_reg + 3'h1;
    end
  end

  // Combinational so the tick lines up with the modem tick that completes it.
  assign baud_tick = modem_tick && (count_reg == 3'(modem_cfg_pkg::BAUD_CLK_DIVISOR - 1));

  // Exactly one baud tick for every eight modem ticks.
  AST_BAUD_EIGHT: assert property (@(posedge clk) disable iff (srst)
    baud_tick |=> (!baud_tick until_with (modem_tick && count_reg == 3'h6)))
    else $error("Baud tick spacing is not eight modem ticks.");
endmodule : modem_baud_divider
`default_nettype wire

// >>> hw/modem_deviation_afc_filter_regs.sv
// Configuration registers for transmit deviation, frequency tracking and channel filter.
//
// Behaviour
// - Shaping bit enables Gaussian transmit shaping.
// - Low band deviation uses exponent minus sixteen.
// - High band deviation uses exponent minus fifteen.
// - Zero transmit mantissa selects on-off keying.
// - Settling field selects tracking off or averaging.
// - Expected receive deviation from baud, mantissa, exponent.
// - Bypass bit skips analog image filter.
// - Decimator input shifted by programmed extra bits.
// - Decimation clock divided by code plus one.
// - Baud rate is modem clock over eight.
`timescale 1ns/10ps
`default_nettype none
module modem_deviation_afc_filter_regs
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave.
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Modem timing ticks, same clock domain.
  input wire logic modem_tick,
  input wire logic decim_tick,
  // Band select: high for the upper band.
  input wire logic high_band,
  // Transmit controls.
  output logic tx_shaping_en,
  output logic ook_mode,
  output logic [2:0] tx_dev_exponent,
  output logic [3:0] tx_dev_mantissa,
  output logic [4:0] tx_dev_shift,
  // Frequency tracking controls.
  output logic afc_enable,
  output logic [5:0] afc_avg_pairs,
  output logic [1:0] rx_dev_exponent,
  output logic [3:0] rx_dev_mantissa,
  output logic baud_tick,
  // Channel filter controls.
  output logic filter_bypass,
  output logic [1:0] decim_input_shift,
  output logic [4:0] decim_clock_divisor,
  output logic [5:0] decim_divide_by,
  output logic decim_clk_en
);
  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic access_pending_reg; // High in the cycle the answer is given.
  logic hit_dev; // Address selects the deviation register.
  logic hit_track; // Address selects the tracking register.
  logic hit_filter; // Address selects the filter register.
  logic hit_any; // Address selects any mapped register.
  logic wr_lane0; // Write strobe with the low byte lane enabled.

  assign hit_dev = (avs_address == modem_cfg_pkg::ADDR_FREQ_DEVIATION_CFG);
  assign hit_track = (avs_address == modem_cfg_pkg::ADDR_FREQ_TRACK_CFG);
  assign hit_filter = (avs_address == modem_cfg_pkg::ADDR_CHANNEL_FILTER_CFG);
  assign hit_any = hit_dev || hit_track || hit_filter;
  // A write only takes effect in the answer cycle, so it lands exactly once.
  assign wr_lane0 = avs_write && access_pending_reg && avs_byteenable[0];

  // One wait state: every request is answered on its second cycle.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      access_pending_reg <= 1'b0;
    end
    else if ((avs_read || avs_write) && !access_pending_reg)
    begin
      access_pending_reg <= 1'b1;
    end
    else
    begin
      access_pending_reg <= 1'b0;
    end
  end

  // Waitrequest is combinational so it drops in the answer cycle.
  assign avs_waitrequest = (avs_read || avs_write) && !access_pending_reg;

  // ****************************************************************
  // Deviation register
  // ****************************************************************
  logic [7:0] dev_reg; // Shaping, exponent and mantissa of transmit deviation.

  // Loads defaults on reset and holds until the next write.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dev_reg <= {modem_cfg_pkg::RST_TX_SHAPING, modem_cfg_pkg::RST_TX_DEV_EXP,
                  modem_cfg_pkg::RST_TX_DEV_MAN};
    end
    else if (wr_lane0 && hit_dev)
    begin
      dev_reg <= avs_writedata[7:0];
    end
  end

  // ****************************************************************
  // Tracking register
  // ****************************************************************
  logic [7:0] track_reg; // Settling mode and expected receive deviation.

  // Loads defaults on reset and holds until the next write.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      track_reg <= {modem_cfg_pkg::RST_SETTLING, modem_cfg_pkg::RST_RX_DEV_EXP,
                    modem_cfg_pkg::RST_RX_DEV_MAN};
    end
    else if (wr_lane0 && hit_track)
    begin
      track_reg <= avs_writedata[7:0];
    end
  end

  // ****************************************************************
  // Filter register
  // ****************************************************************
  logic [7:0] filt_reg; // Bypass, decimator shift and divisor code.

  // Loads defaults on reset and holds until the next write.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      filt_reg <= {modem_cfg_pkg::RST_FILTER_BYPASS, modem_cfg_pkg::RST_DECIM_SHIFT,
                   modem_cfg_pkg::RST_DECIM_DIV};
    end
    else if (wr_lane0 && hit_filter)
    begin
      filt_reg <= avs_writedata[7:0];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data is registered so it stands at the answer edge; unmapped reads give zero.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (avs_read && !access_pending_reg)
    begin
      if (hit_dev)
      begin
        avs_readdata <= {24'h000000, dev_reg};
      end
      else if (hit_track)
      begin
        avs_readdata <= {24'h000000, track_reg};
      end
      else if (hit_filter)
      begin
        avs_readdata <= {24'h000000, filt_reg};
      end
      else
      begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  // Unmapped addresses answer with a slave error, mapped ones with okay.
  assign avs_response = (access_pending_reg && !hit_any) ? 2'h2 : 2'h0;

  // ****************************************************************
  // Transmit field outputs
  // ****************************************************************
  logic [4:0] shift_low; // Exponent minus sixteen, as a right shift.

  assign tx_shaping_en = dev_reg[modem_cfg_pkg::TX_SHAPING_BIT];
  assign tx_dev_exponent = dev_reg[modem_cfg_pkg::TX_DEV_EXP_LSB +: 3];
  assign tx_dev_mantissa = dev_reg[modem_cfg_pkg::TX_DEV_MAN_LSB +: 4];
  // Zero mantissa turns both paths over to on-off keying.
  assign ook_mode = (tx_dev_mantissa == modem_cfg_pkg::OOK_MANTISSA);
  // Deviation is reference times mantissa shifted right by this amount.
  assign shift_low = 5'(modem_cfg_pkg::TX_EXP_BIAS_LOW) - {2'b00, tx_dev_exponent};
  // The upper band shifts one place less, doubling the deviation.
  assign tx_dev_shift = high_band
    ? 5'(modem_cfg_pkg::TX_EXP_BIAS_HIGH) - {2'b00, tx_dev_exponent}
    : shift_low;

  // ****************************************************************
  // Frequency tracking outputs
  // ****************************************************************
  modem_cfg_pkg::afc_mode_type afc_mode; // Decoded settling mode.

  assign afc_mode = modem_cfg_pkg::afc_mode_type'(track_reg[modem_cfg_pkg::SETTLING_LSB +: 2]);
  assign rx_dev_exponent = track_reg[modem_cfg_pkg::RX_DEV_EXP_LSB +: 2];
  assign rx_dev_mantissa = track_reg[modem_cfg_pkg::RX_DEV_MAN_LSB +: 4];

  // Off means the demodulator uses zero average frequency.
  always_comb
  begin
    afc_enable = 1'b1;
    afc_avg_pairs = modem_cfg_pkg::AFC_PAIRS_OFF;
    case (afc_mode)
      modem_cfg_pkg::AFC_OFF:
      begin
        afc_enable = 1'b0;
      end
      modem_cfg_pkg::AFC_FAST:
      begin
        afc_avg_pairs = 6'h01;
      end
      modem_cfg_pkg::AFC_MEDIUM:
      begin
        afc_avg_pairs = 6'h02;
      end
      modem_cfg_pkg::AFC_SLOW:
      begin
        afc_avg_pairs = 6'h04;
      end
      default:
      begin
        afc_enable = 1'b0;
      end
    endcase
  end

  // The receive deviation formula is scaled by this baud tick.
  modem_baud_divider i_modem_baud_divider
  (
    .clk(clk),
    .srst(srst),
    .modem_tick(modem_tick),
    .baud_tick(baud_tick)
  );

  // ****************************************************************
  // Channel filter outputs
  // ****************************************************************
  logic [4:0] decim_count_reg; // Counts decimator ticks within one divided period.

  assign filter_bypass = filt_reg[modem_cfg_pkg::FILTER_BYPASS_BIT];
  assign decim_input_shift = filt_reg[modem_cfg_pkg::DECIM_SHIFT_LSB +: 2];
  assign decim_clock_divisor = filt_reg[modem_cfg_pkg::DECIM_DIV_LSB +: 5];
  assign decim_divide_by = {1'b0, decim_clock_divisor} + 6'h01;

  // Divides the decimator tick by code plus one; a new code is compared from the next decimator tick, mid-period.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      decim_count_reg <= 5'h00;
    end
    else if (decim_tick)
    begin
      if (decim_count_reg >= decim_clock_divisor)
      begin
        decim_count_reg <= 5'h00;
      end
      else
      begin
        decim_count_reg <= decim_count_reg + 5'h01;
      end
    end
  end

  assign decim_clk_en = decim_tick && (decim_count_reg >= decim_clock_divisor);

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_WRITE_DEV: assert property (@(posedge clk) disable iff (srst)
    (wr_lane0 && hit_dev) |=> (dev_reg == $past(avs_writedata[7:0])))
    else $error("Deviation register did not take the write.");

  AST_HOLD_TRACK: assert property (@(posedge clk) disable iff (srst)
    !(wr_lane0 && hit_track) |=> $stable(track_reg))
    else $error("Tracking register changed without a write.");

  AST_READBACK: assert property (@(posedge clk) disable iff (srst)
    (avs_read && !access_pending_reg && hit_filter) |=> (avs_readdata[7:0] == $past(filt_reg)))
    else $error("Filter register read back wrong.");

  AST_OOK: assert property (@(posedge clk) disable iff (srst)
    ook_mode == (dev_reg[3:0] == 4'h0))
    else $error("On-off keying does not follow the mantissa.");

  AST_SHAPING: assert property (@(posedge clk) disable iff (srst)
    (wr_lane0 && hit_dev) |=> (tx_shaping_en == $past(avs_writedata[7])))
    else $error("Shaping enable does not follow the written bit.");

  AST_BAND_SHIFT: assert property (@(posedge clk) disable iff (srst)
    high_band |-> (tx_dev_shift + 5'h01 == shift_low))
    else $error("Upper band shift is not one below the lower band.");

  AST_LOW_SHIFT: assert property (@(posedge clk) disable iff (srst)
    !high_band |-> (tx_dev_shift == 5'h10 - {2'b00, dev_reg[6:4]}))
    else $error("Lower band shift wrong.");

  AST_AFC_OFF: assert property (@(posedge clk) disable iff (srst)
    (track_reg[7:6] == 2'h0) |-> (!afc_enable && afc_avg_pairs == 6'h00))
    else $error("Tracking not disabled by code zero.");

  AST_AFC_PAIRS: assert property (@(posedge clk) disable iff (srst)
    (track_reg[7:6] == 2'h3) |-> (afc_enable && afc_avg_pairs == 6'h04))
    else $error("Slow settling does not average over four pairs.");

  AST_BYPASS: assert property (@(posedge clk) disable iff (srst)
    (wr_lane0 && hit_filter) |=> (filter_bypass == $past(avs_writedata[7])
      && decim_input_shift == $past(avs_writedata[6:5])))
    else $error("Filter bypass or shift did not follow the write.");

  // With divisor code one every second decimator tick passes, whatever the count held before.
  AST_DECIM_DIV: assert property (@(posedge clk) disable iff (srst)
    (decim_tick && decim_clock_divisor == 5'h01) |-> (decim_clk_en == (decim_count_reg != 5'h00)))
    else $error("Decimation divide by two not kept.");

  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (srst)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("Request not answered after one wait state.");
endmodule : modem_deviation_afc_filter_regs
`default_nettype wire

// >>> testbench/modem_deviation_afc_filter_regs_tb_top.sv
// Self-checking testbench for the modem configuration register block.
`timescale 1ns/10ps
`default_nettype none
module modem_deviation_afc_filter_regs_tb_top;
  // ****************************************************************
  // Stimulus, observed outputs and bookkeeping
  // ****************************************************************
  logic clk = 1'b0; // The 25 MHz system clock.
  logic srst = 1'b1; // Synchronous reset, held for the first two cycles.
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h0;
  logic modem_tick = 1'b0; // Ticks stay low outside the divider checks.
  logic decim_tick = 1'b0;
  logic high_band = 1'b0;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response;
  logic avs_waitrequest, tx_shaping_en, ook_mode, afc_enable, baud_tick;
  logic filter_bypass, decim_clk_en;
  logic [2:0] tx_dev_exponent;
  logic [3:0] tx_dev_mantissa, rx_dev_mantissa;
  logic [4:0] tx_dev_shift, decim_clock_divisor;
  logic [5:0] afc_avg_pairs, decim_divide_by;
  logic [1:0] rx_dev_exponent, decim_input_shift;
  int err_total = 0; // Mismatches seen.
  int n_checks = 0; // Comparisons made.
  int seed = 6144; // Fixed seed so every run draws the same values.
  int i;
  logic [31:0] rd; // Read data taken at the accepting edge.
  logic [1:0] resp; // Response taken at the accepting edge.
  logic [7:0] r0, r1, r2; // Expected contents of the three registers.
  // Corner values: every settling code, zero mantissa, divisor extremes.
  logic [23:0] corner [4] = '{24'h000000, 24'h7F7FFF, 24'hF8B801, 24'h8FC8D8};

  modem_deviation_afc_filter_regs i_modem_deviation_afc_filter_regs
  (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .modem_tick(modem_tick), .decim_tick(decim_tick),
    .high_band(high_band), .tx_shaping_en(tx_shaping_en), .ook_mode(ook_mode),
    .tx_dev_exponent(tx_dev_exponent), .tx_dev_mantissa(tx_dev_mantissa),
    .tx_dev_shift(tx_dev_shift), .afc_enable(afc_enable), .afc_avg_pairs(afc_avg_pairs),
    .rx_dev_exponent(rx_dev_exponent), .rx_dev_mantissa(rx_dev_mantissa),
    .baud_tick(baud_tick), .filter_bypass(filter_bypass),
    .decim_input_shift(decim_input_shift), .decim_clock_divisor(decim_clock_divisor),
    .decim_divide_by(decim_divide_by), .decim_clk_en(decim_clk_en)
  );

  // The clock toggles every half period of 20 ns.
  always #20 clk = ~clk;

  // ****************************************************************
  // Expectation functions and checking tasks
  // ****************************************************************
  // Right shift applied to the reference times mantissa in each band.
  function automatic logic [31:0] exp_shift(input logic [2:0] e, input logic hb);
    exp_shift = (hb ? 32'h0000000F : 32'h00000010) - 32'(e);
  endfunction : exp_shift

  // Bit pairs averaged for each settling code; code zero averages none.
  function automatic logic [31:0] exp_pairs(input logic [1:0] c);
    exp_pairs = (c == 2'h0) ? 32'h00000000 : (32'h00000001 << (c - 2'h1));
  endfunction : exp_pairs

  // Prints the verdict and ends the run; the only place the run stops.
  task results;
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // Compares a seen value with the expected one and reports a mismatch.
  task chk(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, want);
    end
  endtask : chk

  // One Avalon-MM transfer, held until waitrequest is sampled low.
  task bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (k == 20)
    begin
      err_total++;
      results();
    end
    rd = avs_readdata;
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Reads a register and compares data and an OKAY response.
  task rd_chk(input logic [9:0] a, input logic [7:0] want);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(rd, {24'h000000, want}, "read data");
    chk(32'(resp), 32'h00000000, "read response");
  endtask : rd_chk

  // Compares every decoded control output with the expected registers.
  task check_outs;
    @(negedge clk);
    chk(32'(tx_shaping_en), 32'(r0[7]), "shaping");
    chk(32'(tx_dev_exponent), 32'(r0[6:4]), "tx exponent");
    chk(32'(tx_dev_mantissa), 32'(r0[3:0]), "tx mantissa");
    chk(32'(tx_dev_shift), exp_shift(r0[6:4], high_band), "tx shift");
    chk(32'(ook_mode), 32'(r0[3:0] == 4'h0), "keying mode");
    chk(32'(afc_enable), 32'(r1[7:6] != 2'h0), "tracking on");
    chk(32'(afc_avg_pairs), exp_pairs(r1[7:6]), "pairs");
    chk(32'(rx_dev_exponent), 32'(r1[5:4]), "rx exponent");
    chk(32'(rx_dev_mantissa), 32'(r1[3:0]), "rx mantissa");
    chk(32'(filter_bypass), 32'(r2[7]), "bypass");
    chk(32'(decim_input_shift), 32'(r2[6:5]), "decim shift");
    chk(32'(decim_clock_divisor), 32'(r2[4:0]), "divisor");
    chk(32'(decim_divide_by), 32'(r2[4:0]) + 32'h00000001, "divide by");
  endtask : check_outs

  // Writes all three registers, reads them back and checks the outputs.
  task put_all(input logic [23:0] v);
    {r0, r1, r2} = v;
    bus(1'b1, modem_cfg_pkg::ADDR_FREQ_DEVIATION_CFG, r0, 4'h1);
    bus(1'b1, modem_cfg_pkg::ADDR_FREQ_TRACK_CFG, r1, 4'h1);
    bus(1'b1, modem_cfg_pkg::ADDR_CHANNEL_FILTER_CFG, r2, 4'h1);
    rd_chk(modem_cfg_pkg::ADDR_FREQ_DEVIATION_CFG, r0);
    rd_chk(modem_cfg_pkg::ADDR_FREQ_TRACK_CFG, r1);
    rd_chk(modem_cfg_pkg::ADDR_CHANNEL_FILTER_CFG, r2);
    check_outs();
  endtask : put_all

  // Pulses a tick every other cycle and measures the spacing of output
  // pulses. The first gap is skipped because the divider phase is unknown.
  task gap_chk(input logic sel, input int want);
    int n;
    int k;
    int t;
    n = 0;
    k = -1;
    for (t = 0; t < 400 && k < 3; t++)
    begin
      @(posedge clk);
      if (sel)
        modem_tick <= 1'b1;
      else
        decim_tick <= 1'b1;
      @(negedge clk);
      n++;
      if ((sel ? baud_tick : decim_clk_en) === 1'b1)
      begin
        if (k >= 0)
          chk(32'(n), 32'(want), "tick gap");
        k++;
        n = 0;
      end
      @(posedge clk);
      modem_tick <= 1'b0;
      decim_tick <= 1'b0;
    end
    if (k < 3)
    begin
      err_total++;
      results();
    end
  endtask : gap_chk

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      // Second pass repeats the reset checks after a mid-run reset.
      r0 = {modem_cfg_pkg::RST_TX_SHAPING, modem_cfg_pkg::RST_TX_DEV_EXP,
            modem_cfg_pkg::RST_TX_DEV_MAN};
      r1 = {modem_cfg_pkg::RST_SETTLING, modem_cfg_pkg::RST_RX_DEV_EXP,
            modem_cfg_pkg::RST_RX_DEV_MAN};
      r2 = {modem_cfg_pkg::RST_FILTER_BYPASS, modem_cfg_pkg::RST_DECIM_SHIFT,
            modem_cfg_pkg::RST_DECIM_DIV};
      rd_chk(modem_cfg_pkg::ADDR_FREQ_DEVIATION_CFG, r0);
      rd_chk(modem_cfg_pkg::ADDR_FREQ_TRACK_CFG, r1);
      rd_chk(modem_cfg_pkg::ADDR_CHANNEL_FILTER_CFG, r2);
      check_outs();
      gap_chk(1'b1, modem_cfg_pkg::BAUD_CLK_DIVISOR);
      if (i == 0)
        put_all(24'h123456);
      @(posedge clk);
      srst <= (i == 0);
      repeat (2) @(posedge clk);
      srst <= 1'b0;
    end
    // Corner table; the last entries follow the host recommendations.
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      high_band <= i[0];
      put_all(corner[i]);
      gap_chk(1'b0, 32'(r2[4:0]) + 1);
    end
    // A write without lane zero must leave the register untouched.
    bus(1'b1, modem_cfg_pkg::ADDR_FREQ_DEVIATION_CFG, ~r0, 4'hE);
    rd_chk(modem_cfg_pkg::ADDR_FREQ_DEVIATION_CFG, r0);
    // Unmapped accesses answer with an error and change nothing.
    bus(1'b1, 10'h044, 8'h55, 4'h1);
    chk(32'(resp), 32'h00000002, "unmapped write response");
    bus(1'b0, 10'h3FC, 8'h00, 4'hF);
    chk(rd, 32'h00000000, "unmapped read data");
    chk(32'(resp), 32'h00000002, "unmapped read response");
    check_outs();
    // Random register contents in both bands.
    for (i = 0; i < 12; i++)
    begin
      @(posedge clk);
      high_band <= 1'($random(seed));
      put_all(24'($random(seed)));
      gap_chk(1'b0, 32'(r2[4:0]) + 1);
    end
    results();
  end
endmodule : modem_deviation_afc_filter_regs_tb_top
`default_nettype wire
